/* File: radio_spi_command_port.sv */
// register side, pin drive and command front end of the radio serial port
`timescale 1ns/1ps
module radio_spi_command_port (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	input  wire logic [7:0]           i_sfr_addr,
	input  wire logic                 i_sfr_wr,
	input  wire logic                 i_sfr_rd,
	input  wire logic [7:0]           i_sfr_wdata,
	output logic [7:0]                o_sfr_rdata,
	input  wire logic                 i_radio_miso,
	output logic                      o_radio_sck,
	output logic                      o_radio_mosi,
	output logic                      o_chip_select_n,
	output logic                      o_chip_enable,
	output logic                      o_radio_clock_enable_pin,
	input  wire logic                 i_radio_idle,
	input  wire logic                 i_feat_dyn_width,
	input  wire logic                 i_feat_ack_pay,
	input  wire logic [5:0]           i_auto_ack_pipe_enables,
	input  wire logic [3:0]           i_retransmit_limit,
	input  wire logic                 i_crc_enable_bit,
	output logic                      o_busy,
	output radio_spi_pkg::cmd_class_t o_cmd_class,
	output logic                      o_reg_wr,
	output logic [4:0]                o_reg_addr,
	output logic [5:0]                o_byte_index,
	output logic [7:0]                o_wr_data,
	output logic                      o_tx_wr,
	output logic                      o_tx_noack,
	output logic                      o_ack_wr,
	output logic [2:0]                o_ack_pipe,
	output logic                      o_flush_tx,
	output logic                      o_flush_rx,
	output logic                      o_reuse_on,
	output logic                      o_rx_pop,
	output logic                      o_pkt_ctrl_field,
	output logic                      o_crc_active
);
	import radio_spi_pkg::*;

	////////////////////////////////////////////////////////////////
	// registers and bus decode

	logic [7:0] pin_ctrl_reg;
	logic [7:0] data_reg;
	logic [7:0] port_ctrl_reg;
	logic       miso_s1_reg;
	logic       miso_s2_reg;
	logic       wr_pin;
	logic       wr_data;
	logic       wr_port;
	logic       port_on;
	logic [7:0] rd_mux;

	assign wr_pin  = i_sfr_wr && (i_sfr_addr == ADDR_PIN_CTRL);
	assign wr_data = i_sfr_wr && (i_sfr_addr == ADDR_DATA);
	assign wr_port = i_sfr_wr && (i_sfr_addr == ADDR_PORT_CTRL);
	assign port_on = port_ctrl_reg[BIT_PORT_EN];

	// unmapped addresses read zero; reserved bits are never stored
	assign rd_mux = (i_sfr_addr == ADDR_PIN_CTRL)  ? pin_ctrl_reg :
	                (i_sfr_addr == ADDR_DATA)      ? data_reg :
	                (i_sfr_addr == ADDR_PORT_CTRL) ? port_ctrl_reg : 8'h00;

	spi_shift_if sh ();

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pin_ctrl_reg <= RST_PIN_CTRL;
			port_ctrl_reg <= RST_PORT_CTRL;
			o_sfr_rdata <= 8'h00;
		end else begin
			if (wr_pin)
				pin_ctrl_reg <= i_sfr_wdata & MASK_PIN_CTRL;
			// upper bits must be written zero; masked so stray ones do no harm
			if (wr_port)
				port_ctrl_reg <= i_sfr_wdata & MASK_PORT_CTRL;
			if (i_sfr_rd)
				o_sfr_rdata <= rd_mux;
		end
	end

	// miso comes from the radio pad, so it is retimed before the shifter
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
		end else begin
			miso_s1_reg <= i_radio_miso;
			miso_s2_reg <= miso_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// pins

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_chip_select_n <= RST_PIN_CTRL[BIT_CSN];
			o_chip_enable <= RST_PIN_CTRL[BIT_CE];
			o_radio_clock_enable_pin <= RST_PIN_CTRL[BIT_RADIO_CLOCK_ENABLE_PIN];
		end else begin
			o_chip_select_n <= pin_ctrl_reg[BIT_CSN];
			o_chip_enable <= pin_ctrl_reg[BIT_CE];
			o_radio_clock_enable_pin <= pin_ctrl_reg[BIT_RADIO_CLOCK_ENABLE_PIN];
		end
	end

	////////////////////////////////////////////////////////////////
	// serial clock divider and byte transfer

	logic [3:0] div_code;
	logic [5:0] half_sel;

	assign div_code = port_ctrl_reg[3:0];
	assign half_sel = (div_code[3:1] == 3'h0) ? HALF_2 :
	                  (div_code == DIV_4)     ? HALF_4 :
	                  (div_code == DIV_8)     ? HALF_8 :
	                  (div_code == DIV_16)    ? HALF_16 :
	                  (div_code == DIV_32)    ? HALF_32 : HALF_64;

	// a data write while the port is off or still shifting is dropped
	assign sh.start = wr_data && port_on && !sh.busy;
	assign sh.tx_byte = i_sfr_wdata;
	assign sh.half_cycles = half_sel;
	assign sh.miso = miso_s2_reg;

	spi_byte_shifter u_shift (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.bus       (sh),
		.o_sck     (o_radio_sck),
		.o_mosi    (o_radio_mosi)
	);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			data_reg <= RST_DATA;
			o_busy <= 1'b0;
		end else begin
			// first byte of a frame returns the radio status
			if (sh.done)
				data_reg <= sh.rx_byte;
			o_busy <= sh.busy || sh.start;
		end
	end

	////////////////////////////////////////////////////////////////
	// frame tracking

	logic       frame_start;
	logic       frame_end;
	logic [5:0] idx_reg;
	logic [7:0] cmd_reg;
	cmd_class_t class_reg;
	cmd_class_t class_dec;

	// frame edges follow the register bit, which is what the pin shows next
	assign frame_start = wr_pin && pin_ctrl_reg[BIT_CSN] && !i_sfr_wdata[BIT_CSN];
	assign frame_end   = wr_pin && !pin_ctrl_reg[BIT_CSN] && i_sfr_wdata[BIT_CSN];


	////////////////////////////////////////////////////////////////
	// command decode of the byte just sent

	logic [7:0] sent_reg;
	logic       is_reg_rd;
	logic       is_reg_wr;
	logic       is_ack;

	// keep what went out on mosi; the received byte is only status
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			sent_reg <= 8'h00;
		else if (sh.start)
			sent_reg <= sh.tx_byte;
	end

	assign is_reg_rd = (sent_reg[7:5] == CMD_REG_RD_TOP);
	assign is_reg_wr = (sent_reg[7:5] == CMD_REG_WR_TOP);
	assign is_ack    = (sent_reg[7:3] == CMD_ACK_TOP) && (sent_reg[2:0] <= MAX_ACK_PIPE);

	always_comb begin
		class_dec = CMD_NONE;
		if (is_reg_rd)
			class_dec = CMD_REG_RD_C;
		else if (is_reg_wr)
			class_dec = i_radio_idle ? CMD_REG_WR_C : CMD_NONE;
		else if (sent_reg == CMD_RX_RD)
			class_dec = CMD_RX_RD_C;
		else if (sent_reg == CMD_TX_WR)
			class_dec = CMD_TX_WR_C;
		else if (sent_reg == CMD_FLUSH_TX)
			class_dec = CMD_FTX_C;
		else if (sent_reg == CMD_FLUSH_RX)
			class_dec = CMD_FRX_C;
		else if (sent_reg == CMD_REUSE)
			class_dec = CMD_REUSE_C;
		else if (sent_reg == CMD_WIDTH_RD)
			class_dec = i_feat_dyn_width ? CMD_WIDTH_C : CMD_NONE;
		else if (is_ack)
			class_dec = i_feat_ack_pay ? CMD_ACK_C : CMD_NONE;
		else if (sent_reg == CMD_TX_NOACK)
			class_dec = CMD_NOACK_C;
		else if (sent_reg == CMD_NOP)
			class_dec = CMD_NOP_C;
	end

	////////////////////////////////////////////////////////////////
	// byte indexing inside a frame

	logic       cmd_byte;
	logic       data_byte;
	logic [5:0] data_idx;
	logic       reg_ok;
	logic       pay_ok;

	assign cmd_byte  = sh.done && (idx_reg == 6'h00);
	assign data_byte = sh.done && (idx_reg != 6'h00);
	assign data_idx  = idx_reg - 6'h01;
	assign reg_ok    = (idx_reg <= MAX_REG_BYTES);
	assign pay_ok    = (idx_reg <= MAX_PAY_BYTES);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			idx_reg <= 6'h00;
			cmd_reg <= 8'h00;
			class_reg <= CMD_NONE;
		end else begin
			if (frame_start) begin
				idx_reg <= 6'h00;
				class_reg <= CMD_NONE;
			end else if (sh.done && !o_chip_select_n && idx_reg != 6'h3f) begin
				idx_reg <= idx_reg + 6'h01;
			end
			if (cmd_byte && !o_chip_select_n) begin
				cmd_reg <= sent_reg;
				class_reg <= class_dec;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// actions toward the radio core

	logic wr_reg_hit;
	logic wr_tx_hit;
	logic wr_ack_hit;
	logic end_no_data;
	logic rx_read_done;

	assign wr_reg_hit = data_byte && (class_reg == CMD_REG_WR_C) && reg_ok;
	assign wr_tx_hit  = data_byte && pay_ok &&
	                    (class_reg == CMD_TX_WR_C || class_reg == CMD_NOACK_C);
	assign wr_ack_hit = data_byte && pay_ok && (class_reg == CMD_ACK_C);
	// zero-data commands act when the frame closes after exactly the command byte
	assign end_no_data = frame_end && (idx_reg == 6'h01);
	assign rx_read_done = frame_end && (class_reg == CMD_RX_RD_C) && (idx_reg > 6'h01);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_reg_wr <= 1'b0;
			o_tx_wr <= 1'b0;
			o_ack_wr <= 1'b0;
			o_tx_noack <= 1'b0;
			o_ack_pipe <= 3'h0;
			o_reg_addr <= 5'h00;
			o_byte_index <= 6'h00;
			o_wr_data <= 8'h00;
			o_flush_tx <= 1'b0;
			o_flush_rx <= 1'b0;
			o_rx_pop <= 1'b0;
			o_cmd_class <= CMD_NONE;
		end else begin
			o_reg_wr <= wr_reg_hit;
			o_tx_wr <= wr_tx_hit;
			o_ack_wr <= wr_ack_hit;
			o_tx_noack <= (class_reg == CMD_NOACK_C);
			o_ack_pipe <= cmd_reg[2:0];
			o_reg_addr <= cmd_reg[4:0];
			o_cmd_class <= class_reg;
			if (data_byte) begin
				o_byte_index <= data_idx;
				o_wr_data <= sent_reg;
			end
			o_flush_tx <= end_no_data && (class_reg == CMD_FTX_C);
			o_flush_rx <= end_no_data && (class_reg == CMD_FRX_C);
			o_rx_pop <= rx_read_done;
		end
	end

	////////////////////////////////////////////////////////////////
	// payload reuse state

	logic reuse_set;
	logic reuse_clr;

	assign reuse_set = end_no_data && (class_reg == CMD_REUSE_C);
	// a new payload or transmit flush ends reuse
	assign reuse_clr = (wr_tx_hit && data_idx == 6'h00) ||
	                   (end_no_data && class_reg == CMD_FTX_C);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			o_reuse_on <= 1'b0;
		else if (reuse_set)
			o_reuse_on <= 1'b1;
		else if (reuse_clr)
			o_reuse_on <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// legacy packet format

	logic legacy;

	// legacy mode is recognised from the settings software must make
	assign legacy = (i_auto_ack_pipe_enables == 6'h00) && (i_retransmit_limit == 4'h0);

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_pkt_ctrl_field <= 1'b1;
			o_crc_active <= 1'b1;
		end else begin
			o_pkt_ctrl_field <= !legacy;
			o_crc_active <= legacy ? i_crc_enable_bit : 1'b1;
		end
	end
endmodule // radio_spi_command_port

/* File: radio_spi_pkg.sv */
// constants and types for the radio serial command port
// How it works
// - legacy mode: packets carry no 9 bit packet control field
// - legacy mode: CRC only when configuration CRC enable bit is set
// - pin control bit1 drives chip select (low active), bit0 chip enable; reset 0x02
// - pin control bit2 gates the 16MHz radio clock
// - port control bit4 enables the serial port; bits 7:5 written zero
// - port control bits 3:0 pick serial clock divider 2 to 64
// - writing the data register starts one byte transfer; read returns the last byte received
// - command byte first, data bytes low byte first, each msb first
// - 000aaaaa reads a radio register, 1 to 5 bytes
// - 001aaaaa writes 1 to 5 bytes, only while radio idle
// - 01100001 reads 1 to 32 received bytes, then pops the payload
// - 10100000 writes 1 to 32 transmit bytes from byte 0
// - 11100001 with no data empties the transmit FIFO
// - 11100010 with no data empties the receive FIFO
// - 11100011 resends last payload until new payload or transmit flush
// - 01100000 returns one byte width of top received payload
// - 10101ppp queues acknowledge payload for pipe 0 to 5
// - 10110000 writes one transmit payload sent without acknowledge
// - 11111111 is a no-op that only shifts out status
// - width read and ack payload commands need enables_a enables set
// - status shifts out during the first byte after chip select falls
// - short register write leaves upper bytes unchanged
package radio_spi_pkg;
	localparam logic [7:0] ADDR_PIN_CTRL  = 8'h90;
	localparam logic [7:0] ADDR_DATA      = 8'he5;
	localparam logic [7:0] ADDR_PORT_CTRL = 8'he6;
	localparam logic [7:0] RST_PIN_CTRL   = 8'h02;
	localparam logic [7:0] RST_DATA       = 8'h00;
	localparam logic [7:0] RST_PORT_CTRL  = 8'h00;
	localparam int BIT_CE = 0;
	localparam int BIT_CSN = 1;
	localparam int BIT_RADIO_CLOCK_ENABLE_PIN = 2;
	localparam int BIT_PORT_EN = 4;
	localparam logic [7:0] MASK_PIN_CTRL  = 8'h07;
	localparam logic [7:0] MASK_PORT_CTRL = 8'h1f;
	localparam logic [3:0] DIV_4  = 4'h2;
	localparam logic [3:0] DIV_8  = 4'h3;
	localparam logic [3:0] DIV_16 = 4'h4;
	localparam logic [3:0] DIV_32 = 4'h5;
	localparam logic [5:0] HALF_2  = 6'h01;
	localparam logic [5:0] HALF_4  = 6'h02;
	localparam logic [5:0] HALF_8  = 6'h04;
	localparam logic [5:0] HALF_16 = 6'h08;
	localparam logic [5:0] HALF_32 = 6'h10;
	localparam logic [5:0] HALF_64 = 6'h20;
	localparam logic [7:0] CMD_RX_RD    = 8'h61;
	localparam logic [7:0] CMD_TX_WR    = 8'ha0;
	localparam logic [7:0] CMD_FLUSH_TX = 8'he1;
	localparam logic [7:0] CMD_FLUSH_RX = 8'he2;
	localparam logic [7:0] CMD_REUSE    = 8'he3;
	localparam logic [7:0] CMD_WIDTH_RD = 8'h60;
	localparam logic [7:0] CMD_TX_NOACK = 8'hb0;
	localparam logic [7:0] CMD_NOP      = 8'hff;
	localparam logic [4:0] CMD_ACK_TOP  = 5'h15;
	localparam logic [2:0] CMD_REG_RD_TOP = 3'h0;
	localparam logic [2:0] CMD_REG_WR_TOP = 3'h1;
	localparam logic [2:0] MAX_ACK_PIPE = 3'h5;
	localparam logic [5:0] MAX_REG_BYTES = 6'h05;
	localparam logic [5:0] MAX_PAY_BYTES = 6'h20;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_REG_RD_C, CMD_REG_WR_C, CMD_RX_RD_C, CMD_TX_WR_C,
		CMD_NOACK_C, CMD_ACK_C, CMD_WIDTH_C, CMD_FTX_C, CMD_FRX_C,
		CMD_REUSE_C, CMD_NOP_C
	} cmd_class_t;
endpackage

/* File: spi_shift_if.sv */
// bundle between the register side and the byte shifter
`timescale 1ns/1ps
interface spi_shift_if;
	logic       start;
	logic [7:0] tx_byte;
	logic [5:0] half_cycles;
	logic       miso;
	logic       busy;
	logic       done;
	logic [7:0] rx_byte;
	modport ctrl  (output start, tx_byte, half_cycles, miso, input busy, done, rx_byte);
	modport shift (input start, tx_byte, half_cycles, miso, output busy, done, rx_byte);
endinterface

/* File: spi_byte_shifter.sv */
// one byte full duplex shifter, clock idles low, miso taken just before the falling edge
`timescale 1ns/1ps
module spi_byte_shifter (
	input  wire logic   i_clk_sys,
	input  wire logic   i_sys_rst,
	spi_shift_if.shift  bus,
	output logic        o_sck,
	output logic        o_mosi
);
	typedef enum logic {SH_IDLE, SH_RUN} shift_state_t;
	shift_state_t state_reg;
	logic [5:0]   cnt_reg;
	logic [2:0]   bit_reg;
	logic [7:0]   sr_reg;
	logic         done_reg;
	logic [7:0]   rx_reg;
	logic         tick;

	assign tick = (cnt_reg == 6'h01);
	assign bus.busy = (state_reg == SH_RUN);
	assign bus.done = done_reg;
	assign bus.rx_byte = rx_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			state_reg <= SH_IDLE;
			cnt_reg <= 6'h00;
			bit_reg <= 3'h0;
			sr_reg <= 8'h00;
			done_reg <= 1'b0;
			rx_reg <= 8'h00;
			o_sck <= 1'b0;
			o_mosi <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				SH_IDLE: begin
					if (bus.start) begin
						state_reg <= SH_RUN;
						sr_reg <= bus.tx_byte;
						o_mosi <= bus.tx_byte[7];
						cnt_reg <= bus.half_cycles;
						bit_reg <= 3'h0;
					end
				end
				SH_RUN: begin
					cnt_reg <= tick ? bus.half_cycles : cnt_reg - 6'h01;
					// miso arrives two flops late; a rising edge sample would still see
					// the previous bit when the half period is a single cycle
					if (tick && !o_sck) begin
						o_sck <= 1'b1;
					end else if (tick) begin
						o_sck <= 1'b0;
						sr_reg <= {sr_reg[6:0], bus.miso};
						o_mosi <= sr_reg[6];
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7) begin
							state_reg <= SH_IDLE;
							rx_reg <= {sr_reg[6:0], bus.miso};
							done_reg <= 1'b1;
						end
					end
				end
				default: state_reg <= SH_IDLE;
			endcase
		end
	end
endmodule // spi_byte_shifter

/* File: radio_spi_monitor.sv */
// concurrent checks on the radio serial command port
`timescale 1ns/1ps
module radio_spi_monitor
	import radio_spi_pkg::*;
(
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	input  wire logic [7:0]           i_sfr_addr,
	input  wire logic                 i_sfr_wr,
	input  wire logic [7:0]           i_sfr_wdata,
	input  wire logic                 o_radio_sck,
	input  wire logic                 o_radio_mosi,
	input  wire logic                 o_chip_select_n,
	input  wire logic                 o_chip_enable,
	input  wire logic                 o_radio_clock_enable_pin,
	input  wire logic                 o_busy,
	input  radio_spi_pkg::cmd_class_t o_cmd_class,
	input  wire logic                 o_reg_wr,
	input  wire logic [5:0]           o_byte_index,
	input  wire logic                 o_tx_wr,
	input  wire logic                 o_reuse_on,
	input  wire logic                 o_ack_wr,
	input  wire logic [2:0]           o_ack_pipe,
	input  wire logic                 o_flush_rx
);
	logic       port_q;
	logic [3:0] div_q;
	logic [5:0] hi_cnt;
	logic [3:0] n_rise;
	logic       sck_q;
	logic [5:0] exp_half;
	logic       data_wr;
	assign data_wr = i_sfr_wr && i_sfr_addr == ADDR_DATA;
	assign exp_half = (div_q[3:1] == 3'h0) ? HALF_2 : (div_q == DIV_4) ? HALF_4 : (div_q == DIV_8) ? HALF_8 :
		(div_q == DIV_16) ? HALF_16 : (div_q == DIV_32) ? HALF_32 : HALF_64;
	////////////////////////////////////////////////////////////////////////
	// shadow of the port control and serial clock bookkeeping
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || (i_sfr_wr && i_sfr_addr == ADDR_PORT_CTRL)) begin
			port_q <= i_sys_rst ? 1'b0 : i_sfr_wdata[BIT_PORT_EN];
			div_q  <= i_sys_rst ? 4'h0 : i_sfr_wdata[3:0];
		end
		hi_cnt <= (i_sys_rst || !o_radio_sck) ? 6'h00 : hi_cnt + 6'h01;
		sck_q  <= i_sys_rst ? 1'b0 : o_radio_sck;
		// count restarts only when idle, a refused write must not disturb it
		if (i_sys_rst || (data_wr && !o_busy))
			n_rise <= 4'h0;
		else if (o_radio_sck && !sck_q)
			n_rise <= n_rise + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	AST_PINS: assert property (i_sfr_wr && i_sfr_addr == ADDR_PIN_CTRL |-> ##2
		{o_radio_clock_enable_pin, o_chip_select_n, o_chip_enable} == $past(i_sfr_wdata[2:0], 2))
		else $error("pin outputs do not follow pin control write");
	AST_BUSY_START: assert property (data_wr && port_q && !o_busy |=> o_busy)
		else $error("accepted data write did not start a transfer");
	AST_REFUSE: assert property (data_wr && !port_q && !o_busy |=> !o_busy)
		else $error("transfer started with port disabled");
	AST_SCK_IDLE: assert property (!o_busy |-> !o_radio_sck)
		else $error("serial clock active while idle");
	AST_DIV: assert property ($fell(o_radio_sck) |-> hi_cnt == exp_half)
		else $error("serial clock high time does not match divider");
	AST_MOSI_STABLE: assert property (o_radio_sck |-> $stable(o_radio_mosi))
		else $error("serial out changed while clock high");
	AST_EIGHT: assert property ($fell(o_busy) |-> n_rise == 4'h8)
		else $error("transfer did not carry eight clock pulses");
	AST_REUSE_CLR: assert property (o_tx_wr |-> ##[1:2] !o_reuse_on)
		else $error("payload byte did not clear resend state");
	AST_REG_IDX: assert property (o_reg_wr |-> o_byte_index < MAX_REG_BYTES && o_cmd_class == CMD_REG_WR_C)
		else $error("register write pulse out of range");
	AST_ACK_PIPE: assert property (o_ack_wr |-> o_ack_pipe <= MAX_ACK_PIPE)
		else $error("ack payload for invalid pipe");
	COV_REG_WR: cover property (o_reg_wr);
	COV_ACK_WR: cover property (o_ack_wr);
	COV_FLUSH_RX: cover property (o_flush_rx);
endmodule // radio_spi_monitor

bind radio_spi_command_port radio_spi_monitor i_radio_spi_monitor (.i_clk_sys, .i_sys_rst, .i_sfr_addr, .i_sfr_wr,
	.i_sfr_wdata, .o_radio_sck, .o_radio_mosi, .o_chip_select_n, .o_chip_enable, .o_radio_clock_enable_pin,
	.o_busy, .o_cmd_class, .o_reg_wr, .o_byte_index, .o_tx_wr, .o_reuse_on, .o_ack_wr, .o_ack_pipe, .o_flush_rx);

/* File: radio_far_model.sv */
// behavioural radio end of the serial link
`timescale 1ns/1ps
module radio_far_model #(
	parameter logic [7:0] STATUS = 8'h0e,
	parameter logic [7:0] REPLY  = 8'ha5
) (
	input  wire logic       i_sck,
	input  wire logic       i_mosi,
	input  wire logic       i_chip_select_n,
	output logic            o_miso,
	output logic [7:0]      o_last_rx
);
	logic [7:0] out_reg = 8'h00;
	logic [7:0] cap_reg = 8'h00;
	int         bits = 0;
	initial o_last_rx = 8'h00;
	// released line shows the inverse of the last bit, never a held value
	assign o_miso = out_reg[7] ^ i_chip_select_n;
	always @(negedge i_chip_select_n) begin
		out_reg = STATUS;
		bits = 0;
	end
	always @(posedge i_sck) if (!i_chip_select_n) begin
		cap_reg = {cap_reg[6:0], i_mosi};
		bits++;
		if (bits % 8 == 0) o_last_rx = cap_reg;
	end
	always @(negedge i_sck) if (!i_chip_select_n)
		out_reg = (bits % 8 == 0) ? REPLY : {out_reg[6:0], ~out_reg[7]};
endmodule // radio_far_model

/* File: testbench.sv */
// self-checking bench for the radio serial command port
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t mismatch", $time); end end
module testbench;
	import radio_spi_pkg::*;
	localparam logic [7:0] STATUS = 8'h0e;
	localparam logic [7:0] REPLY  = 8'ha5;
	logic             i_clk_sys, i_sys_rst, i_sfr_wr, i_sfr_rd, i_radio_miso, i_radio_idle;
	logic             i_feat_dyn_width, i_feat_ack_pay, i_crc_enable_bit;
	logic [7:0]       i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_wr_data, rx, st, last_rx;
	logic [5:0]       i_auto_ack_pipe_enables, o_byte_index;
	logic [3:0]       i_retransmit_limit;
	logic             o_radio_sck, o_radio_mosi, o_chip_select_n, o_chip_enable, o_radio_clock_enable_pin;
	logic             o_busy, o_reg_wr, o_tx_wr, o_tx_noack, o_ack_wr, o_flush_tx, o_flush_rx;
	logic             o_reuse_on, o_rx_pop, o_pkt_ctrl_field, o_crc_active;
	logic [4:0]       o_reg_addr;
	logic [2:0]       o_ack_pipe, pipe_q;
	cmd_class_t       o_cmd_class, cls;
	logic [15:0]      q[$];
	int               cnt[6];
	int               sck_hi, failures, compares;
	logic [3:0]       codes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
	int               halfs[8] = '{1, 1, 2, 4, 8, 16, 32, 32};
	radio_spi_command_port i_radio_spi_command_port (.i_clk_sys, .i_sys_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
		.i_sfr_wdata, .o_sfr_rdata, .i_radio_miso, .o_radio_sck, .o_radio_mosi, .o_chip_select_n, .o_chip_enable,
		.o_radio_clock_enable_pin, .i_radio_idle, .i_feat_dyn_width, .i_feat_ack_pay, .i_auto_ack_pipe_enables,
		.i_retransmit_limit, .i_crc_enable_bit, .o_busy, .o_cmd_class, .o_reg_wr, .o_reg_addr, .o_byte_index,
		.o_wr_data, .o_tx_wr, .o_tx_noack, .o_ack_wr, .o_ack_pipe, .o_flush_tx, .o_flush_rx, .o_reuse_on,
		.o_rx_pop, .o_pkt_ctrl_field, .o_crc_active);
	radio_far_model #(.STATUS(STATUS), .REPLY(REPLY)) i_radio_far_model (.i_sck(o_radio_sck),
		.i_mosi(o_radio_mosi), .i_chip_select_n(o_chip_select_n), .o_miso(i_radio_miso), .o_last_rx(last_rx));
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	// pulse counters, sampled at every rising clock edge
	always @(posedge i_clk_sys) begin
		sck_hi += o_radio_sck;
		cnt[0] += o_reg_wr;
		cnt[1] += o_tx_wr;
		cnt[2] += o_ack_wr;
		cnt[3] += o_flush_tx;
		cnt[4] += o_flush_rx;
		cnt[5] += o_rx_pop;
		if (o_reg_wr) q.push_back({o_reg_addr, o_byte_index[2:0], o_wr_data});
		if (o_ack_wr) pipe_q = o_ack_pipe;
	end
	task finish_test();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one register cycle; read data lands in rx
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_wr <= w;
		i_sfr_rd <= !w;
		@(posedge i_clk_sys);
		i_sfr_wr <= 1'b0;
		i_sfr_rd <= 1'b0;
		@(posedge i_clk_sys);
		#1 rx = o_sfr_rdata;
	endtask
	task xb(input logic [7:0] d);
		int k;
		sck_hi = 0;
		bus(1'b1, ADDR_DATA, d);
		for (k = 0; k < 3000 && o_busy === 1'b1; k++) @(posedge i_clk_sys) #1;
		if (o_busy !== 1'b0) begin
			failures++;
			finish_test();
		end
		bus(1'b0, ADDR_DATA, 8'h00);
	endtask
	task frame(input logic [7:0] c, input int n);
		cnt = '{default:0};
		q.delete();
		bus(1'b1, ADDR_PIN_CTRL, 8'h04);
		xb(c);
		st = rx;
		cls = o_cmd_class;
		for (int i = 0; i < n; i++) xb(8'h40 + 8'(i));
		bus(1'b1, ADDR_PIN_CTRL, 8'h06);
		repeat (3) @(posedge i_clk_sys);
		#1;
	endtask
	task run(input logic [7:0] c, input int n, input int k, input int e);
		frame(c, n);
		`CHK(cnt[k], e)
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{i_sfr_wr, i_sfr_rd, i_feat_dyn_width, i_feat_ack_pay} = 4'h0;
		{i_sfr_addr, i_sfr_wdata} = 16'h0000;
		{i_radio_idle, i_crc_enable_bit} = 2'b11;
		i_auto_ack_pipe_enables = 6'h3f;
		i_retransmit_limit = 4'h3;
		i_sys_rst = 1'b1;
		repeat (5) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		bus(1'b0, ADDR_PIN_CTRL, 8'h00);
		`CHK(rx, RST_PIN_CTRL)
		`CHK({o_radio_clock_enable_pin, o_chip_select_n, o_chip_enable}, 3'b010)
		bus(1'b0, 8'h80, 8'h00);
		`CHK(rx, 8'h00)
		bus(1'b1, ADDR_PIN_CTRL, 8'hff);
		bus(1'b0, ADDR_PIN_CTRL, 8'h00);
		`CHK(rx, 8'h07)
		`CHK({o_radio_clock_enable_pin, o_chip_select_n, o_chip_enable}, 3'b111)
		bus(1'b1, ADDR_PIN_CTRL, 8'h06);
		bus(1'b1, ADDR_PORT_CTRL, 8'he3);
		bus(1'b0, ADDR_PORT_CTRL, 8'h00);
		`CHK(rx, 8'h03)
		xb(8'h11);
		`CHK(rx, RST_DATA)
		`CHK(sck_hi, 0)
		foreach (codes[i]) begin
			bus(1'b1, ADDR_PORT_CTRL, {4'h1, codes[i]});
			xb(8'hff);
			`CHK(sck_hi, 8 * halfs[i])
		end
		bus(1'b1, ADDR_PORT_CTRL, 8'h13);
		frame(CMD_NOP, 0);
		`CHK(st, STATUS)
		`CHK(cls, CMD_NOP_C)
		`CHK(last_rx, CMD_NOP)
		frame(8'h03, 2);
		`CHK(rx, REPLY)
		`CHK(cls, CMD_REG_RD_C)
		run(8'h25, 6, 0, 5);
		`CHK(q[0], {5'h05, 3'h0, 8'h40})
		`CHK(q[1], {5'h05, 3'h1, 8'h41})
		`CHK(last_rx, 8'h45)
		run(8'h22, 1, 0, 1);
		@(posedge i_clk_sys) i_radio_idle <= 1'b0;
		run(8'h25, 1, 0, 0);
		`CHK(cls, CMD_NONE)
		run(CMD_FLUSH_TX, 0, 3, 1);
		run(CMD_FLUSH_TX, 1, 3, 0);
		run(CMD_FLUSH_RX, 0, 4, 1);
		run(CMD_REUSE, 0, 3, 0);
		`CHK(o_reuse_on, 1'b1)
		run(CMD_TX_WR, 3, 1, 3);
		`CHK(o_reuse_on, 1'b0)
		`CHK(o_tx_noack, 1'b0)
		run(CMD_TX_NOACK, 2, 1, 2);
		`CHK(cls, CMD_NOACK_C)
		`CHK(o_tx_noack, 1'b1)
		run(8'haa, 2, 2, 0);
		`CHK(cls, CMD_NONE)
		run(CMD_WIDTH_RD, 1, 5, 0);
		`CHK(cls, CMD_NONE)
		@(posedge i_clk_sys) {i_feat_dyn_width, i_feat_ack_pay} <= 2'b11;
		run(8'haa, 2, 2, 2);
		`CHK(pipe_q, 3'h2)
		run(8'hae, 1, 2, 0);
		run(CMD_WIDTH_RD, 1, 5, 0);
		`CHK(cls, CMD_WIDTH_C)
		`CHK(rx, REPLY)
		run(CMD_RX_RD, 2, 5, 1);
		run(CMD_RX_RD, 0, 5, 0);
		`CHK(o_pkt_ctrl_field, 1'b1)
		@(posedge i_clk_sys) {i_auto_ack_pipe_enables, i_retransmit_limit, i_crc_enable_bit} <= 11'h000;
		repeat (3) @(posedge i_clk_sys);
		#1 `CHK(o_pkt_ctrl_field, 1'b0)
		`CHK(o_crc_active, 1'b0)
		@(posedge i_clk_sys) i_crc_enable_bit <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		#1 `CHK(o_crc_active, 1'b1)
		finish_test();
	end
endmodule // testbench
